// *** logic/sbed_pkg.sv ***
/*
  Package for the serial bus error-detect block: register map, field codes,
  status bit positions, counter presets and the event carrier struct.
  Assumes the bit-level engine runs on the same clock as this block.
*/
package sbed_pkg;
  // Register indices on the plain host port
  localparam logic [3:0] ADDR_DATA = 4'h0;    // bus_data_register
  localparam logic [3:0] ADDR_ISR = 4'h1;     // interrupt status, W1C
  localparam logic [3:0] ADDR_SSR = 4'h2;     // slave_status_register
  localparam logic [3:0] ADDR_MASK = 4'h3;    // interrupt mask
  localparam logic [3:0] ADDR_FRAME = 4'h4;   // frame_byte_counter
  localparam logic [3:0] ADDR_SUCC = 4'h5;    // success_byte_counter
  localparam logic [3:0] ADDR_LEN = 4'h6;     // byte count preset

  // Status bit positions
  localparam int ISR_ERR_BIT = 6;             // comm_error_flag
  localparam int ISR_CEND_BIT = 3;            // communication end
  localparam int ISR_FEND_BIT = 2;            // frame end
  localparam int SSR_RX_BIT = 1;              // rx_byte_pending_flag
  localparam int SSR_TX_BIT = 0;              // transmit byte pending

  // Reset values and presets
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [5:0] FRAME_MAX = 6'h20;   // 32 bytes per frame
  localparam logic [5:0] FRAME_ZERO = 6'h00;
  localparam logic [5:0] FRAME_ONE = 6'h01;
  localparam logic [8:0] SUCC_ZERO = 9'h000;
  localparam logic [8:0] SUCC_ONE = 9'h001;
  localparam logic [8:0] SUCC_FULL = 9'h100;  // length 00h means 256

  // Field being carried on the line
  typedef enum logic [1:0] {
    FLD_ADDR = 2'b00,
    FLD_CTRL = 2'b01,
    FLD_LEN = 2'b10,
    FLD_DATA = 2'b11
  } sbed_field_t;

  // Events from the bit-level engine, one-cycle pulses unless noted
  typedef struct packed {
    logic frameStart;     // new frame begins, counters preset
    logic broadcast;      // level: frame is broadcast
    logic lostToSlave;    // level: we asked broadcast, lost, now slave
    logic addressed;      // level: frame is for this unit
    logic rxRole;         // level: this unit receives the current field
    logic timingErr;      // bit width out of range
    logic parityChk;      // parity bit of a field has arrived
    logic parityCalc;     // locally computed parity
    logic parityRx;       // received parity bit
    logic ackSlot;        // acknowledge slot of the current field
    logic nackSeen;       // as transmitter: NACK read in the slot
    sbed_field_t field;   // level: current field
    logic rxStart;        // reception timing of a data byte begins
    logic rxByteDone;     // data byte fully received
    logic [7:0] rxData;   // byte with rxByteDone
    logic txTake;         // transmitter took the byte for sending
  } sbed_evt_t;

  // Answers to the bit-level engine
  typedef struct packed {
    logic ackValid;       // pulse: ackBit applies to this slot
    logic ackBit;         // 1 = acknowledge, 0 = withhold
    logic rxStop;         // level: broadcast reception halted
    logic [7:0] txData;   // byte to send next
  } sbed_resp_t;
endpackage : sbed_pkg

// *** logic/sbed_error_detect.sv ***
/*
  Error detection and overrun handling of the serial bus controller.
  Holds the data register, counters, status and mask registers.
  Assumes a same-clock bit engine that supplies sbed_evt_t pulses and a
  host using the plain one-cycle register port.
*/
`timescale 1ns/1ps
module sbed_error_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire sbed_pkg::sbed_evt_t evt,
  output sbed_pkg::sbed_resp_t resp,
  output logic data_transfer_irq,
  output logic comm_status_irq,
  output logic comm_error_flag,
  output logic rx_byte_pending_flag
);
  import sbed_pkg::*;

  logic [7:0] busDataRx_reg;
  logic [7:0] busDataTx_reg;
  logic [7:0] isr_reg;
  logic [7:0] isr_next;
  logic [7:0] mask_reg;
  logic [7:0] len_reg;
  logic [5:0] frameCnt_reg;
  logic [8:0] succCnt_reg;
  logic pending_reg;
  logic overrun_reg;
  logic txFresh_reg;
  logic rxStop_reg;
  logic hdrParityBad_reg;
  logic parityBad;
  logic parityIrq;
  logic nackErr;
  logic underrun;
  logic bcastOvr;
  logic dataAck;
  logic dataAckRx;
  logic dataOk;
  logic rxRefused_reg;
  logic ackValid_reg;
  logic ackBit_reg;
  logic errEvent;
  logic frameEndEvt;
  logic commEndEvt;
  logic hostReadData;
  logic [7:0] setBits;

  // Byte counter preset, 00h stands for 256
  function automatic logic [8:0] succPreset(input logic [7:0] len);
    succPreset = (len == BYTE_ZERO) ? SUCC_FULL : {1'b0, len};
  endfunction : succPreset

  // Parity check and its interrupt qualification
  assign parityBad = evt.parityChk && evt.rxRole &&
                     (evt.parityCalc != evt.parityRx);
  assign parityIrq = parityBad && evt.addressed &&
    ((evt.field != FLD_DATA) ||
     (evt.broadcast && !evt.lostToSlave));

  // NACK seen by the transmitter outside the data field
  assign nackErr = evt.ackSlot && !evt.rxRole && evt.nackSeen &&
                   (evt.field != FLD_DATA);

  // Data acknowledge slots, for both roles
  assign dataAck = evt.ackSlot && evt.addressed && (evt.field == FLD_DATA);
  assign dataAckRx = dataAck && evt.rxRole;

  // Underrun: next byte not written before the ack of the current one
  assign underrun = dataAck && !evt.rxRole && !txFresh_reg &&
                    (succCnt_reg > SUCC_ONE);

  // Broadcast overrun: next byte starts with the previous one unread
  assign bcastOvr = evt.rxStart && evt.addressed && evt.broadcast &&
                    pending_reg && !rxStop_reg;

  assign errEvent = evt.timingErr || parityIrq || nackErr || underrun ||
                    bcastOvr;
  assign frameEndEvt = dataAck && (frameCnt_reg == FRAME_ONE);

  // Byte counts as delivered: accepted here, or acknowledged by the peer.
  // Judged in this slot, not from the answer left over from the last one.
  assign dataOk = evt.rxRole ? (!rxRefused_reg && !hdrParityBad_reg)
                             : !evt.nackSeen;
  assign commEndEvt = dataAck && dataOk && (succCnt_reg == SUCC_ONE);
  assign hostReadData = regRd && (regAddr == ADDR_DATA);

  // Status set bits and write-one-to-clear, set wins over clear
  always_comb begin
    setBits = BYTE_ZERO;
    setBits[ISR_ERR_BIT] = errEvent;
    setBits[ISR_FEND_BIT] = frameEndEvt;
    setBits[ISR_CEND_BIT] = commEndEvt;
    isr_next = isr_reg;
    if (regWr && (regAddr == ADDR_ISR)) begin
      isr_next = isr_reg & ~regWdata;
    end
    isr_next = isr_next | setBits;
  end

  // Interrupt status and mask
  always_ff @(posedge clk) begin
    if (rst) begin
      isr_reg <= BYTE_ZERO;
      mask_reg <= MASK_RESET;
      len_reg <= BYTE_ZERO;
    end else begin
      isr_reg <= isr_next;
      if (regWr && (regAddr == ADDR_MASK)) begin
        mask_reg <= regWdata;
      end
      if (regWr && (regAddr == ADDR_LEN)) begin
        len_reg <= regWdata;
      end
    end
  end

  // Interrupt outputs registered from the next status, on the same edge as the status register
  always_ff @(posedge clk) begin
    if (rst) begin
      comm_status_irq <= 1'b0;
      comm_error_flag <= 1'b0;
    end else begin
      comm_status_irq <= |(isr_next & ~mask_reg);   // Mask bit set blocks
      comm_error_flag <= isr_next[ISR_ERR_BIT];
    end
  end

  // Transmit byte register and freshness for underrun detection
  always_ff @(posedge clk) begin
    if (rst) begin
      busDataTx_reg <= BYTE_ZERO;
      txFresh_reg <= 1'b0;
    end else begin
      if (regWr && (regAddr == ADDR_DATA)) begin
        busDataTx_reg <= regWdata;
        txFresh_reg <= 1'b1;
      end else if (evt.txTake) begin
        txFresh_reg <= 1'b0;
      end
    end
  end

  // Receive byte register and pending flag
  always_ff @(posedge clk) begin
    if (rst) begin
      busDataRx_reg <= BYTE_ZERO;
      pending_reg <= 1'b0;
      data_transfer_irq <= 1'b0;
    end else begin
      if (evt.rxByteDone && evt.addressed && !overrun_reg &&
          !rxStop_reg && !pending_reg) begin
        busDataRx_reg <= evt.rxData;
        pending_reg <= 1'b1;
        data_transfer_irq <= 1'b1;
      end else if (hostReadData) begin
        pending_reg <= 1'b0;
        data_transfer_irq <= 1'b0;
      end
    end
  end

  // Overrun state: set on start with unread byte, cleared on the next start after a read
  always_ff @(posedge clk) begin
    if (rst) begin
      overrun_reg <= 1'b0;
    end else if (evt.rxStart && evt.addressed) begin
      overrun_reg <= pending_reg;
    end
  end

  // Broadcast reception halt, lifted at the next frame
  always_ff @(posedge clk) begin
    if (rst) begin
      rxStop_reg <= 1'b0;
    end else if (bcastOvr) begin
      rxStop_reg <= 1'b1;
    end else if (evt.frameStart) begin
      rxStop_reg <= 1'b0;
    end
  end

  // Refusal of the byte just completed, held for its acknowledge slot;
  // the pending flag alone would refuse the very byte just stored
  always_ff @(posedge clk) begin
    if (rst) begin
      rxRefused_reg <= 1'b0;
    end else if (evt.rxByteDone) begin
      rxRefused_reg <= overrun_reg || rxStop_reg || pending_reg ||
                       !evt.addressed;
    end
  end

  // Header parity result kept for the following acknowledge slot
  always_ff @(posedge clk) begin
    if (rst) begin
      hdrParityBad_reg <= 1'b0;
    end else if (evt.parityChk) begin
      hdrParityBad_reg <= parityBad;
    end
  end

  // Acknowledge answer to the bit engine
  always_ff @(posedge clk) begin
    if (rst) begin
      ackValid_reg <= 1'b0;
      ackBit_reg <= 1'b0;
    end else begin
      ackValid_reg <= evt.ackSlot && evt.rxRole && evt.addressed;
      if (evt.ackSlot && evt.rxRole) begin
        if (evt.field == FLD_DATA) begin
          ackBit_reg <= !rxRefused_reg && !hdrParityBad_reg;
        end else begin
          ackBit_reg <= !hdrParityBad_reg;
        end
      end
    end
  end

  // Answer bundle, one driver, every field straight from a flip-flop
  assign resp = {ackValid_reg, ackBit_reg, rxStop_reg, busDataTx_reg};

  // Frame and success byte counters
  always_ff @(posedge clk) begin
    if (rst) begin
      frameCnt_reg <= FRAME_MAX;
      succCnt_reg <= SUCC_ZERO;
    end else if (evt.frameStart) begin
      frameCnt_reg <= FRAME_MAX;
      succCnt_reg <= succPreset(len_reg);
    end else if (dataAck) begin
      if (frameCnt_reg != FRAME_ZERO) begin
        frameCnt_reg <= frameCnt_reg - FRAME_ONE;
      end
      if (dataOk && succCnt_reg != SUCC_ZERO) begin
        succCnt_reg <= succCnt_reg - SUCC_ONE;
      end
    end
  end

  // Pending output mirrors the slave status bit
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_byte_pending_flag <= 1'b0;
    end else begin
      rx_byte_pending_flag <= pending_reg || bcastOvr;
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdata <= BYTE_ZERO;
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_DATA: regRdata <= busDataRx_reg;
        ADDR_ISR: regRdata <= isr_reg;
        ADDR_SSR: regRdata <= {6'h00, pending_reg, txFresh_reg};
        ADDR_MASK: regRdata <= mask_reg;
        ADDR_FRAME: regRdata <= {2'h0, frameCnt_reg};
        ADDR_SUCC: regRdata <= succCnt_reg[7:0];
        ADDR_LEN: regRdata <= len_reg;
        default: regRdata <= BYTE_ZERO;
      endcase
    end else begin
      regRdata <= BYTE_ZERO;
    end
  end

  // Checks
  sequence seqOvrStart;
    evt.rxStart && evt.addressed && pending_reg && !evt.broadcast;
  endsequence
  sequence seqDataAckRx;
    evt.ackSlot && evt.rxRole && evt.addressed && evt.field == FLD_DATA;
  endsequence

  AST_HDR_PARITY: assert property (@(posedge clk) disable iff (rst)
    parityBad && evt.addressed && evt.field != FLD_DATA
    |=> isr_reg[ISR_ERR_BIT])
    else $error("header parity error not flagged");
  AST_BC_PARITY: assert property (@(posedge clk) disable iff (rst)
    parityBad && evt.addressed && evt.broadcast && !evt.lostToSlave
    |=> comm_error_flag)
    else $error("broadcast data parity error not flagged");
  AST_LOST_PARITY: assert property (@(posedge clk) disable iff (rst)
    parityBad && evt.field == FLD_DATA && evt.lostToSlave &&
    !isr_reg[ISR_ERR_BIT] && !errEvent |=> !isr_reg[ISR_ERR_BIT])
    else $error("lost-contention parity raised error");
  AST_NACK: assert property (@(posedge clk) disable iff (rst)
    nackErr |=> isr_reg[ISR_ERR_BIT])
    else $error("header nack not flagged");
  AST_UNDERRUN: assert property (@(posedge clk) disable iff (rst)
    dataAck && !evt.rxRole && !txFresh_reg && succCnt_reg > SUCC_ONE
    |=> isr_reg[ISR_ERR_BIT])
    else $error("underrun not flagged");
  AST_OVR_NOACK: assert property (@(posedge clk) disable iff (rst)
    seqDataAckRx ##0 overrun_reg
    |=> resp.ackValid && !resp.ackBit)
    else $error("ack given during overrun");
  AST_OVR_COUNT: assert property (@(posedge clk) disable iff (rst)
    seqDataAckRx and overrun_reg && !evt.frameStart
    |=> succCnt_reg == $past(succCnt_reg))
    else $error("success count moved on refused byte");
  AST_BC_KEEP: assert property (@(posedge clk) disable iff (rst)
    bcastOvr |=> rxStop_reg && $stable(busDataRx_reg) && rx_byte_pending_flag)
    else $error("broadcast overrun handling wrong");
  AST_OVR_CLEAR: assert property (@(posedge clk) disable iff (rst)
    evt.rxStart && evt.addressed && !pending_reg |=> !overrun_reg)
    else $error("overrun not cleared");
  AST_HDR_ACK: assert property (@(posedge clk) disable iff (rst)
    evt.ackSlot && evt.rxRole && evt.addressed && evt.field != FLD_DATA &&
    !hdrParityBad_reg |=> resp.ackValid && resp.ackBit)
    else $error("header ack withheld");
  AST_FRAME_END: assert property (@(posedge clk) disable iff (rst)
    dataAck && frameCnt_reg == FRAME_ONE && !evt.frameStart
    |=> isr_reg[ISR_FEND_BIT] && frameCnt_reg == FRAME_ZERO)
    else $error("frame end missing");
  AST_OVR_SET: assert property (@(posedge clk) disable iff (rst)
    seqOvrStart |=> overrun_reg)
    else $error("overrun not declared");
  AST_DATA_ACK: assert property (@(posedge clk) disable iff (rst)
    dataAckRx && !rxRefused_reg && !hdrParityBad_reg
    |=> resp.ackValid && resp.ackBit)
    else $error("accepted byte not acknowledged");
  AST_FOREIGN_KEEP: assert property (@(posedge clk) disable iff (rst)
    evt.rxByteDone && !evt.addressed |=> $stable(busDataRx_reg))
    else $error("foreign byte stored");
  AST_TIMING_ERR: assert property (@(posedge clk) disable iff (rst)
    evt.timingErr |=> isr_reg[ISR_ERR_BIT])
    else $error("timing error not flagged");
  AST_ERR_HOLD: assert property (@(posedge clk) disable iff (rst)
    isr_reg[ISR_ERR_BIT] &&
    !(regWr && regAddr == ADDR_ISR && regWdata[ISR_ERR_BIT])
    |=> isr_reg[ISR_ERR_BIT])
    else $error("error flag dropped without host write");
endmodule : sbed_error_detect

// *** testbench/sbed_bus.sv ***
/*
  Behavioural model of the serial bus bit engine that faces the
  error-detect block: frames, fields, data bytes and transmit takes.
  Assumes it shares clk with the block; the bench calls its tasks.
*/
`timescale 1ns/1ps
module sbed_bus (
  input wire logic clk,
  output sbed_pkg::sbed_evt_t evt,
  input wire sbed_pkg::sbed_resp_t resp
);
  import sbed_pkg::*;
  logic gotAck; // Answer seen in the last slot, x when none came

  // Quiet line at time zero
  initial begin
    evt = '0;
    gotAck = 1'bx;
  end

  // Open a frame with its level qualifiers
  task automatic frame(input logic bc, input logic lost, input logic adr);
    @(posedge clk);
    evt.broadcast <= bc;
    evt.lostToSlave <= lost;
    evt.addressed <= adr;
    evt.frameStart <= 1'b1;
    @(posedge clk);
    evt.frameStart <= 1'b0;
  endtask : frame

  // Parity bit, then acknowledge slot; the answer is captured
  task automatic fld(input sbed_field_t f, input logic rx, input logic perr,
                     input logic nack);
    @(posedge clk);
    evt.field <= f;
    evt.rxRole <= rx;
    evt.parityChk <= 1'b1;
    evt.parityCalc <= f[0];
    evt.parityRx <= f[0] ^ perr;
    @(posedge clk);
    evt.parityChk <= 1'b0;
    evt.parityRx <= ~(f[0] ^ perr); // Released bit shows the inverse
    evt.ackSlot <= 1'b1;
    evt.nackSeen <= nack;
    @(posedge clk);
    evt.ackSlot <= 1'b0;
    evt.nackSeen <= 1'b0;
    #1;
    gotAck = resp.ackValid ? resp.ackBit : 1'bx;
    repeat (3) @(posedge clk);
  endtask : fld

  // One received data byte: start, byte, parity and slot
  task automatic rxByte(input logic [7:0] d);
    @(posedge clk);
    evt.field <= FLD_DATA;
    evt.rxRole <= 1'b1;
    evt.rxStart <= 1'b1;
    @(posedge clk);
    evt.rxStart <= 1'b0;
    evt.rxByteDone <= 1'b1;
    evt.rxData <= d;
    @(posedge clk);
    evt.rxByteDone <= 1'b0;
    evt.rxData <= ~d; // Stale byte must not be mistaken for data
    fld(FLD_DATA, 1'b1, 1'b0, 1'b0);
  endtask : rxByte

  // Bit width out of range, one pulse, then let the flag settle
  task automatic tErr;
    @(posedge clk);
    evt.timingErr <= 1'b1;
    @(posedge clk);
    evt.timingErr <= 1'b0;
    @(posedge clk);
  endtask : tErr

  // Transmitter takes the next byte from the data register
  task automatic take;
    @(posedge clk);
    evt.txTake <= 1'b1;
    @(posedge clk);
    evt.txTake <= 1'b0;
  endtask : take
endmodule : sbed_bus

// *** testbench/sbed_error_detect_tb_top.sv ***
/*
  Self-checking bench for the serial bus error-detect block.
  Assumes the bus model sbed_bus and one 50 MHz clock.
*/
`timescale 1ns/1ps
module sbed_error_detect_tb_top;
  import sbed_pkg::*;
  logic clk;
  logic rst;
  logic [3:0] regAddr;
  logic [7:0] regWdata;
  logic regWr;
  logic regRd;
  logic [7:0] regRdata;
  sbed_evt_t evt;
  sbed_resp_t resp;
  logic dataIrq;
  logic statusIrq;
  logic errFlag;
  logic rxPend;
  int mismatches;
  int n_checks;
  int cycles;
  logic [7:0] rdv;

  sbed_error_detect u_sbed_error_detect (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .evt(evt), .resp(resp),
    .data_transfer_irq(dataIrq), .comm_status_irq(statusIrq),
    .comm_error_flag(errFlag), .rx_byte_pending_flag(rxPend));
  sbed_bus u_sbed_bus (.clk(clk), .evt(evt), .resp(resp));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  // Register port: one-cycle strobes, read data in the next cycle only
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd

  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk8(v, exp);
  endtask : rdChk

  // Drop pending byte and all status, then let flags settle
  task automatic clean;
    rd(ADDR_DATA, rdv);
    wr(ADDR_ISR, 8'hff);
    repeat (3) @(posedge clk);
  endtask : clean

  task automatic t_reset;
    rdChk(ADDR_FRAME, {2'b00, FRAME_MAX});
    rdChk(ADDR_SUCC, SUCC_ZERO[7:0]);
    rdChk(ADDR_MASK, MASK_RESET);
    wr(4'h9, 8'hff);
    rdChk(4'h9, BYTE_ZERO);
    chk1(errFlag, 1'b0);
    u_sbed_bus.tErr();
    chk1(errFlag, 1'b1);
    clean();
    chk1(errFlag, 1'b0);
  endtask : t_reset

  task automatic t_parity;
    for (int i = 0; i < 8; i++) begin
      u_sbed_bus.frame(1'b0, 1'b0, 1'b1);
      u_sbed_bus.fld(sbed_field_t'(i[1:0]), 1'b1, i[2], 1'b0);
      chk1(errFlag, i[2] && i[1:0] != 2'b11);
      clean();
    end
    u_sbed_bus.frame(1'b1, 1'b0, 1'b1);
    u_sbed_bus.fld(FLD_DATA, 1'b1, 1'b1, 1'b0);
    chk1(errFlag, 1'b1);
    clean();
    chk1(errFlag, 1'b0);
    u_sbed_bus.frame(1'b1, 1'b1, 1'b1);
    u_sbed_bus.fld(FLD_DATA, 1'b1, 1'b1, 1'b0);
    chk1(errFlag, 1'b0);
    chk1(statusIrq, 1'b0);
  endtask : t_parity

  task automatic t_nack_irq;
    for (int i = 0; i < 3; i++) begin
      u_sbed_bus.frame(1'b0, 1'b0, 1'b1);
      u_sbed_bus.fld(sbed_field_t'(i[1:0]), 1'b0, 1'b0, 1'b1);
      chk1(errFlag, 1'b1);
      chk1(statusIrq, 1'b1);
      if (i == 2) begin
        wr(ADDR_MASK, 8'h40);
        repeat (3) @(posedge clk);
        chk1(statusIrq, 1'b0);
        chk1(errFlag, 1'b1);
        wr(ADDR_MASK, MASK_RESET);
      end
      clean();
      chk1(statusIrq, 1'b0);
    end
  endtask : t_nack_irq

  task automatic t_underrun;
    wr(ADDR_LEN, 8'h03);
    u_sbed_bus.frame(1'b0, 1'b0, 1'b1);
    wr(ADDR_DATA, 8'h11);
    u_sbed_bus.take();
    wr(ADDR_DATA, 8'h22);
    #1;
    chk8(resp.txData, 8'h22);
    u_sbed_bus.fld(FLD_DATA, 1'b0, 1'b0, 1'b0);
    chk1(errFlag, 1'b0);
    u_sbed_bus.take();
    u_sbed_bus.fld(FLD_DATA, 1'b0, 1'b0, 1'b0);
    chk1(errFlag, 1'b1);
    clean();
  endtask : t_underrun

  task automatic t_overrun;
    wr(ADDR_LEN, 8'h05);
    u_sbed_bus.frame(1'b0, 1'b0, 1'b1);
    u_sbed_bus.rxByte(8'ha1);
    chk1(u_sbed_bus.gotAck, 1'b1);
    chk1(dataIrq, 1'b1);
    u_sbed_bus.rxByte(8'hb2);
    chk1(u_sbed_bus.gotAck, 1'b0);
    rdChk(ADDR_FRAME, 8'h1e);
    rdChk(ADDR_SUCC, 8'h04);
    rdChk(ADDR_DATA, 8'ha1);
    u_sbed_bus.rxByte(8'hb2);
    chk1(u_sbed_bus.gotAck, 1'b1);
    rdChk(ADDR_DATA, 8'hb2);
    u_sbed_bus.frame(1'b1, 1'b0, 1'b1);
    u_sbed_bus.rxByte(8'hf6);
    u_sbed_bus.rxByte(8'h07);
    chk1(errFlag, 1'b1);
    chk1(resp.rxStop, 1'b1);
    chk1(rxPend, 1'b1);
    rdChk(ADDR_DATA, 8'hf6);
    clean();
  endtask : t_overrun

  task automatic t_frame_end;
    u_sbed_bus.frame(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 32; i++) begin
      u_sbed_bus.rxByte(8'hc3 ^ i[7:0]);
    end
    rd(ADDR_ISR, rdv);
    chk1(rdv[ISR_FEND_BIT], 1'b1);
    u_sbed_bus.frame(1'b0, 1'b0, 1'b1);
    u_sbed_bus.fld(FLD_ADDR, 1'b1, 1'b0, 1'b0);
    chk1(u_sbed_bus.gotAck, 1'b1);
    u_sbed_bus.rxByte(8'h5a);
    chk1(u_sbed_bus.gotAck, 1'b0);
    u_sbed_bus.frame(1'b0, 1'b0, 1'b0);
    u_sbed_bus.rxByte(8'he5);
    chk1(errFlag, 1'b0);
    rdChk(ADDR_DATA, 8'hc3);
  endtask : t_frame_end

  // Reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_parity();
    t_nack_irq();
    t_underrun();
    t_overrun();
    t_frame_end();
    wrap_up();
  end
endmodule : sbed_error_detect_tb_top
